// >>> ams_sequencer.v
// ADC input multiplexer sequencer with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ams_defs.vh"
module ams_sequencer #(
   parameter SLOW_HZ = 32768,
   parameter CLK_HZ  = 40000000
) (
   clk,
   rst,
   slow_clock,
   system_power,
   awaddr, awvalid, awready, wdata, wstrb, wvalid, wready,
   bresp, bvalid, bready,
   araddr, arvalid, arready, rdata, rresp, rvalid, rready,
   mux_select,
   battery_connect,
   chop_polarity,
   diff_mode,
   diff_chop_swap,
   conv_start,
   frame_sync,
   result_valid,
   result_addr,
   sequencer_control
);
   input  wire        clk;
   input  wire        rst;
   input  wire        slow_clock;
   input  wire        system_power;
   input  wire [7:0]  awaddr;
   input  wire        awvalid;
   output reg         awready;
   input  wire [31:0] wdata;
   input  wire [3:0]  wstrb;
   input  wire        wvalid;
   output reg         wready;
   output reg  [1:0]  bresp;
   output reg         bvalid;
   input  wire        bready;
   input  wire [7:0]  araddr;
   input  wire        arvalid;
   output reg         arready;
   output reg  [31:0] rdata;
   output reg  [1:0]  rresp;
   output reg         rvalid;
   input  wire        rready;
   output reg  [3:0]  mux_select;
   output reg         battery_connect;
   output reg         chop_polarity;
   output reg  [3:0]  diff_mode;
   output reg         diff_chop_swap;
   output reg         conv_start;
   output reg         frame_sync;
   output reg         result_valid;
   output reg  [3:0]  result_addr;
   output reg         sequencer_control;

   localparam ST_SLOT = 2'b01;
   localparam ST_GAP  = 2'b10;

   reg [31:0] ctrl_ff;
   reg [39:0] nsel_ff;
   reg [39:0] asel_ff;
   reg        alt_pend_ff;
   reg        alt_frame_ff;
   reg [3:0]  slots_ff;
   reg [1:0]  flen_ff;
   reg [3:0]  slot_ff;
   reg [1:0]  tick_ff;
   reg [1:0]  state_ff;
   reg [2:0]  sck_ff;
   reg        sck_seen_ff;
   reg [2:0]  pwr_ff;
   reg        pwr_ok_ff;
   reg        alt_taken_ff;
   reg [7:0]  awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0]  wstrb_ff;
   reg        aw_ok_ff;
   reg        w_ok_ff;

   wire [1:0] chop_mode    = ctrl_ff[`AMS_CHOP_LSB+1:`AMS_CHOP_LSB];
   // Power loss reaches the battery load about five clocks late
   wire       bme_eff      = ctrl_ff[`AMS_BME_BIT] & pwr_ok_ff;
   // Edge taken only when the second and third stages agree
   wire       sck_rise     = sck_ff[1] & sck_ff[2] & ~sck_seen_ff;
   wire       sck_fall     = ~sck_ff[1] & ~sck_ff[2];
   wire       slot_last_t  = (tick_ff == flen_ff);
   wire       frame_last   = (slot_ff + 4'd1 >= slots_ff);
   wire [3:0] sel_norm     = nsel_ff[slot_ff*4 +: 4];
   wire [3:0] sel_alt      = asel_ff[slot_ff*4 +: 4];
   wire [3:0] sel_now      = alt_frame_ff ? sel_alt : sel_norm;
   wire [3:0] cfg_slots    = ctrl_ff[`AMS_SLOTS_LSB+3:`AMS_SLOTS_LSB];
   wire [3:0] nxt_slots    = (cfg_slots == 4'd0) ? 4'd1 :
                             (cfg_slots > `AMS_MAX_SLOTS) ? `AMS_MAX_SLOTS : cfg_slots;
   wire [1:0] cfg_flen     = ctrl_ff[`AMS_FLEN_LSB+1:`AMS_FLEN_LSB];
   wire [1:0] nxt_flen     = (cfg_flen == 2'd3) ? 2'd2 : cfg_flen;
   wire       wr_fire      = aw_ok_ff & w_ok_ff & ~bvalid;
   wire [31:0] wmask       = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                              {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   wire       alt_set      = wr_fire & (awaddr_ff == `AMS_CTRL_ADDR) & wstrb_ff[0]
                             & wdata_ff[`AMS_ALT_BIT] & ~ctrl_ff[`AMS_ALT_BIT];

   // Slow clock is sampled through three flops, only the first is raw
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_ff      <= 3'b000;
         sck_seen_ff <= 1'b0;
      end else begin
         sck_ff <= {sck_ff[1:0], slow_clock};
         if (sck_rise)
            sck_seen_ff <= 1'b1;
         else if (sck_fall)
            sck_seen_ff <= 1'b0;
      end
   end

   // Power flag is asynchronous; filtered like the slow clock
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_ff    <= 3'b000;
         pwr_ok_ff <= 1'b0;
      end else begin
         pwr_ff <= {pwr_ff[1:0], system_power};
         if (pwr_ff[1] == pwr_ff[2])
            pwr_ok_ff <= pwr_ff[2];
      end
   end

   // AXI4-Lite write path, address and data taken in either order
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_ok_ff  <= 1'b0;
         w_ok_ff   <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `AMS_RESP_OK;
         ctrl_ff   <= `AMS_CTRL_RST;
         nsel_ff   <= 40'h0;
         asel_ff   <= 40'h0;
      end else begin
         if (awvalid & awready) begin
            awaddr_ff <= awaddr;
            aw_ok_ff  <= 1'b1;
            awready   <= 1'b0;
         end
         if (wvalid & wready) begin
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
            w_ok_ff  <= 1'b1;
            wready   <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= `AMS_RESP_OK;
            case (awaddr_ff)
               `AMS_CTRL_ADDR: ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask);
               `AMS_NSEL_LO:   nsel_ff[31:0] <= (nsel_ff[31:0] & ~wmask) | (wdata_ff & wmask);
               `AMS_NSEL_HI: begin
                  if (wstrb_ff[0])
                     nsel_ff[39:32] <= wdata_ff[7:0];
               end
               `AMS_ASEL_LO:   asel_ff[31:0] <= (asel_ff[31:0] & ~wmask) | (wdata_ff & wmask);
               `AMS_ASEL_HI: begin
                  if (wstrb_ff[0])
                     asel_ff[39:32] <= wdata_ff[7:0];
               end
               default:        bresp <= `AMS_RESP_ERR;
            endcase
         end
         if (bvalid & bready) begin
            bvalid   <= 1'b0;
            aw_ok_ff <= 1'b0;
            w_ok_ff  <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
         end
      end
   end

   // AXI4-Lite read path
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `AMS_RESP_OK;
      end else begin
         if (arvalid & arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `AMS_RESP_OK;
            case (araddr)
               `AMS_CTRL_ADDR: rdata <= ctrl_ff;
               `AMS_STAT_ADDR: rdata <= {18'h0, slots_ff, flen_ff, chop_polarity,
                                         alt_frame_ff, alt_pend_ff, frame_sync, slot_ff};
               `AMS_NSEL_LO:   rdata <= nsel_ff[31:0];
               `AMS_NSEL_HI:   rdata <= {24'h0, nsel_ff[39:32]};
               `AMS_ASEL_LO:   rdata <= asel_ff[31:0];
               `AMS_ASEL_HI:   rdata <= {24'h0, asel_ff[39:32]};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= `AMS_RESP_ERR;
               end
            endcase
         end
         if (rvalid & rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Sequencer, advancing only on qualified slow clock edges
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff          <= ST_GAP;
         slot_ff           <= 4'd0;
         tick_ff           <= 2'd0;
         slots_ff          <= 4'd7;
         flen_ff           <= 2'd0;
         alt_pend_ff       <= 1'b0;
         alt_frame_ff      <= 1'b0;
         alt_taken_ff      <= 1'b0;
         chop_polarity     <= 1'b0;
         diff_chop_swap    <= 1'b0;
         mux_select        <= 4'd0;
         battery_connect   <= 1'b0;
         diff_mode         <= 4'h0;
         conv_start        <= 1'b0;
         frame_sync        <= 1'b0;
         result_valid      <= 1'b0;
         result_addr       <= 4'd0;
         sequencer_control <= 1'b0;
      end else begin
         conv_start        <= 1'b0;
         result_valid      <= 1'b0;
         sequencer_control <= 1'b0;
         diff_mode         <= ctrl_ff[`AMS_DIFF_LSB+3:`AMS_DIFF_LSB];
         battery_connect   <= bme_eff;
         // Set wins over the consumption clear; one pending flag, no queue
         if (alt_set)
            alt_pend_ff <= 1'b1;
         else if (alt_taken_ff)
            alt_pend_ff <= 1'b0;
         alt_taken_ff <= 1'b0;
         if (sck_rise) begin
            sequencer_control <= 1'b1;
            case (state_ff)
               ST_SLOT: begin
                  if (!slot_last_t) begin
                     tick_ff <= tick_ff + 2'd1;
                  end else begin
                     // Result closes the slot for every filter length
                     result_valid <= 1'b1;
                     result_addr  <= mux_select;
                     if (frame_last) begin
                        state_ff   <= ST_GAP;
                        frame_sync <= 1'b1;
                        if (chop_mode == `AMS_CHOP_POS)
                           chop_polarity <= 1'b0;
                        else if (chop_mode == `AMS_CHOP_REV)
                           chop_polarity <= 1'b1;
                        else
                           chop_polarity <= ~chop_polarity;
                        diff_chop_swap <= ~diff_chop_swap;
                     end else begin
                        slot_ff    <= slot_ff + 4'd1;
                        tick_ff    <= 2'd0;
                        conv_start <= 1'b1;
                     end
                  end
               end
               ST_GAP: begin
                  state_ff     <= ST_SLOT;
                  frame_sync   <= 1'b0;
                  slot_ff      <= 4'd0;
                  tick_ff      <= 2'd0;
                  conv_start   <= 1'b1;
                  slots_ff     <= nxt_slots;
                  flen_ff      <= nxt_flen;
                  alt_frame_ff <= alt_pend_ff & ~alt_set;
                  alt_taken_ff <= alt_pend_ff & ~alt_set;
               end
               default: state_ff <= ST_GAP;
            endcase
         end
         // Alternate-list battery code replaced by the normal entry unless measurement is enabled
         if ((sel_now == `AMS_SIG_BAT) && !bme_eff)
            mux_select <= sel_norm;
         else
            mux_select <= sel_now;
      end
   end

   // Alternate bit in control is a plain latch of what software wrote
endmodule // ams_sequencer

// >>> ams_defs.vh
// Constants for the ADC input multiplexer sequencer
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH
`define AMS_ADDR_W       8
`define AMS_CTRL_ADDR    8'h00
`define AMS_STAT_ADDR    8'h04
`define AMS_NSEL_LO      8'h08
`define AMS_NSEL_HI      8'h0c
`define AMS_ASEL_LO      8'h10
`define AMS_ASEL_HI      8'h14
`define AMS_MAX_SLOTS    4'd10
`define AMS_SEL_W        4
`define AMS_SLOTS_LSB    0
`define AMS_FLEN_LSB     4
`define AMS_ALT_BIT      6
`define AMS_BME_BIT      7
`define AMS_CHOP_LSB     8
`define AMS_DIFF_LSB     12
`define AMS_CTRL_RST     32'h0000_0007
`define AMS_CHOP_POS     2'b01
`define AMS_CHOP_REV     2'b10
`define AMS_SIG_BAT      4'hb
`define AMS_RESP_OK      2'b00
`define AMS_RESP_ERR     2'b10
`endif

// >>> ams_check_sva.sv
// Port assertions for the input multiplexer sequencer
`timescale 1ns/1ps
module ams_check (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        system_power,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        battery_connect,
   input wire logic        conv_start,
   input wire logic        frame_sync,
   input wire logic        result_valid,
   input wire logic        sequencer_control
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Gap is one slow cycle, far longer than eight clocks
   sequence s_gap_hold;
      frame_sync [*8];
   endsequence
   a_gap_hold: assert property ($rose(frame_sync) |-> s_gap_hold)
      else $error("frame gap too short");
   a_gap_idle: assert property (frame_sync |-> !conv_start)
      else $error("conversion started in gap");
   a_ctrl_pulse: assert property (sequencer_control |=> !sequencer_control)
      else $error("control pulse too long");
   a_conv_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start too long");
   a_result_pulse: assert property (result_valid |=> !result_valid)
      else $error("result strobe too long");
   a_battery_off: assert property (!system_power [*2] |-> ##4 !battery_connect)
      else $error("battery load without power");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
endmodule // ams_check

// >>> ams_slow_src.sv
// Free-running slow clock source standing in for the analog side
`timescale 1ns/1ps
module ams_slow_src #(
   parameter int HALF = 20
) (
   input wire logic clk,
   input wire logic rst,
   output logic     slow_clock
);
   int cnt_ff;
   // Short period keeps runs brief; clock never stops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 0;
         slow_clock <= 1'b0;
      end else if (cnt_ff == HALF - 1) begin
         cnt_ff <= 0;
         slow_clock <= ~slow_clock;
      end else begin
         cnt_ff <= cnt_ff + 1;
      end
   end
endmodule // ams_slow_src

// >>> tb.sv
// Self-checking bench for the input multiplexer sequencer
`timescale 1ns/1ps
`include "ams_defs.vh"
module tb;
   localparam int HALF = 20;
   logic        clk, rst, system_power, slow_clock;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, mux_select, diff_mode, result_addr;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, battery_connect;
   logic        chop_polarity, diff_chop_swap, conv_start, frame_sync;
   logic        result_valid, sequencer_control;
   int          err_count, samples_checked;
   ams_slow_src #(.HALF(HALF)) ams_slow_src_i (.clk(clk), .rst(rst), .slow_clock(slow_clock));
   ams_sequencer ams_sequencer_i (.clk(clk), .rst(rst), .slow_clock(slow_clock),
      .system_power(system_power), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mux_select(mux_select), .battery_connect(battery_connect),
      .chop_polarity(chop_polarity), .diff_mode(diff_mode), .diff_chop_swap(diff_chop_swap),
      .conv_start(conv_start), .frame_sync(frame_sync), .result_valid(result_valid),
      .result_addr(result_addr), .sequencer_control(sequencer_control));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit pa, pw, pb;
      pa = 1;
      pw = 1;
      pb = 1;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b0;
      while (pa || pw || pb) begin
         @(posedge clk);
         pa = pa && !awready;
         pw = pw && !wready;
         awvalid <= pa;
         wvalid <= pw;
         if (pb && bvalid && bready) chk(bresp, er);
         pb = pb && !(bvalid && bready);
         bready <= pb && bvalid;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      bit pa, pr;
      pa = 1;
      pr = 1;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b0;
      while (pa || pr) begin
         @(posedge clk);
         pa = pa && !arready;
         arvalid <= pa;
         if (pr && rvalid && rready) begin
            chk(rdata, exp);
            chk(rresp, er);
         end
         pr = pr && !(rvalid && rready);
         rready <= pr && rvalid;
      end
   endtask
   // Waits for a gap, checks the next three-slot frame, returns as the frame after it starts
   task chk_frame(input logic [11:0] sel);
      while (!frame_sync) @(posedge clk);
      while (frame_sync) @(posedge clk);
      for (int n = 0; n < 3; n++) begin
         @(posedge clk);
         while (!result_valid) @(posedge clk);
         chk(result_addr, sel[4*n +: 4]);
         chk(mux_select, sel[4*n +: 4]);
      end
      @(posedge clk);
      while (!result_valid && !frame_sync) @(posedge clk);
      chk(frame_sync, 1'b1);
      while (frame_sync) @(posedge clk);
   endtask
   task t_regs;
      rd(`AMS_CTRL_ADDR, `AMS_CTRL_RST, `AMS_RESP_OK);
      rd(8'h20, 32'h0, `AMS_RESP_ERR);
      wr(8'h20, 32'h0, `AMS_RESP_ERR);
      wr(`AMS_NSEL_LO, 32'h0000_0210, `AMS_RESP_OK);
      wr(`AMS_ASEL_LO, 32'h0000_0b1a, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a003, `AMS_RESP_OK);
      rd(`AMS_CTRL_ADDR, 32'h0000_a003, `AMS_RESP_OK);
      chk(diff_mode, 4'ha);
   endtask
   task t_frames;
      chk_frame(12'h210);
      // Two rising edges while pending must still give one frame
      wr(`AMS_CTRL_ADDR, 32'h0000_a043, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a003, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a043, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a003, `AMS_RESP_OK);
      chk_frame(12'h21a);
      chk_frame(12'h210);
      wr(`AMS_CTRL_ADDR, 32'h0000_a0c3, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a083, `AMS_RESP_OK);
      chk(battery_connect, 1'b1);
      chk_frame(12'hb1a);
   endtask
   task t_power;
      system_power <= 1'b0;
      repeat (6) @(posedge clk);
      chk(battery_connect, 1'b0);
      system_power <= 1'b1;
      repeat (6) @(posedge clk);
      chk(battery_connect, 1'b1);
   endtask
   task t_timing;
      int c;
      logic sw;
      for (int f = 0; f < 3; f++) begin
         wr(`AMS_CTRL_ADDR, {16'h0, 4'ha, 2'b00, (f == 1) ? 2'b10 : 2'b01, 2'b00, f[1:0],
            4'h3}, `AMS_RESP_OK);
         sw = diff_chop_swap;
         while (!frame_sync) @(posedge clk);
         while (frame_sync) @(posedge clk);
         chk(chop_polarity, f == 1);
         chk(diff_chop_swap, !sw);
         while (!result_valid) @(posedge clk);
         c = 0;
         do begin
            @(posedge clk);
            c++;
         end while (!result_valid);
         chk(c, (f + 1) * 2 * HALF);
      end
   endtask
   // Six-slot frame without neutral: seventh entries left unused
   task t_six;
      int k;
      wr(`AMS_NSEL_LO, 32'h0054_3210, `AMS_RESP_OK);
      wr(`AMS_CTRL_ADDR, 32'h0000_a006, `AMS_RESP_OK);
      while (!frame_sync) @(posedge clk);
      while (frame_sync) @(posedge clk);
      k = 0;
      while (!frame_sync) begin
         @(posedge clk);
         if (result_valid) begin
            chk(result_addr, k);
            k++;
         end
      end
      chk(k, 6);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim;
   end
   initial begin
      {rst, system_power, wstrb} = 6'h3f;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {err_count, samples_checked} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_frames;
      t_power;
      t_timing;
      t_six;
      end_sim;
   end
endmodule // tb
bind ams_sequencer ams_check ams_check_i (.clk(clk), .rst(rst), .system_power(system_power),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .battery_connect(battery_connect), .conv_start(conv_start), .frame_sync(frame_sync),
   .result_valid(result_valid), .sequencer_control(sequencer_control));
